// *** core/aux_scaler_pkg.sv ***
// Purpose: shared constants and types for the auxiliary input scaler
// Assumes: samples are signed counts, 1 mV per count, 10 V = 10000
// Notes: gain and bias are signed tenths of a percent
package aux_scaler_pkg;
  localparam int NUM_CH = 3;
  localparam int ADDR_W = 8;
  // register map: channel in bits [5:4], field in bits [3:2]
  localparam int CH_LSB = 4;
  localparam int FLD_LSB = 2;
  localparam logic [1:0] FLD_POL = 2'h0;
  localparam logic [1:0] FLD_OFFSET = 2'h1;
  localparam logic [1:0] FLD_SCALE = 2'h2;
  localparam logic [1:0] FLD_RESULT = 2'h3;
  localparam logic [1:0] ADDR_TOP_ZERO = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [31:0] POL_CODE_MAX = 32'h0000_0002;
  // limits and reset values, tenths of a percent
  localparam logic signed [15:0] GAIN_MIN = 16'shE0C0; // -800.0 %
  localparam logic signed [15:0] GAIN_MAX = 16'sh1F40; // 800.0 %
  localparam logic signed [15:0] GAIN_RST = 16'sh03E8; // 100.0 %
  localparam logic signed [15:0] BIAS_MIN = 16'shF060; // -400.0 %
  localparam logic signed [15:0] BIAS_MAX = 16'sh0FA0; // 400.0 %
  localparam logic signed [15:0] BIAS_RST = 16'sh0000;
  localparam logic signed [15:0] ZERO16 = 16'sh0000;
  localparam logic signed [15:0] SAT_MAX = 16'sh7FFF;
  localparam logic signed [15:0] SAT_MIN = 16'sh8000;
  // counts per 0.1 % of full scale, and a bias bound of 300.0 % that cannot saturate
  localparam logic signed [15:0] BIAS_STEP = 16'sh000A;
  localparam logic signed [15:0] BIAS_LINEAR_MAX = 16'sh0BB8;
  // 100.0 % in tenths, and 10 V in counts
  localparam logic signed [32:0] PCT_UNITY = 33'sh0_0000_03E8;
  localparam logic signed [32:0] FULL_SCALE_COUNTS = 33'sh0_0000_2710;
  typedef enum logic [1:0] {
    POL_BIPOLAR = 2'h0,
    POL_POS_ONLY = 2'h1,
    POL_NEG_ONLY = 2'h2
  } polarity_t;
endpackage

// *** core/aux_channel_math.sv ***
// Purpose: gain, bias, saturation and polarity for one sample
// Assumes: gain and bias already clamped to their legal ranges
// Notes: purely combinational, the caller registers the result
`timescale 1ns/1ps
module aux_channel_math
  import aux_scaler_pkg::*;
(
  input wire logic signed [15:0] sample,
  input wire logic signed [15:0] gain,
  input wire logic signed [15:0] bias,
  input wire polarity_t pol,
  output logic signed [15:0] result
);
  logic signed [32:0] prod_term;
  logic signed [32:0] bias_term;
  logic signed [32:0] sum;
  logic signed [32:0] quot;
  logic signed [15:0] sat;

  // gain first, then bias; one division keeps rounding in one place
  always_comb begin
    prod_term = 33'(sample) * 33'(gain);
    bias_term = 33'(bias) * FULL_SCALE_COUNTS;
    sum = prod_term + bias_term;
    quot = sum / PCT_UNITY; // truncates toward zero
  end

  // clip instead of wrapping so a large gain cannot flip the sign
  // saturate, never wrap
  always_comb begin
    if (quot > 33'(SAT_MAX)) begin
      sat = SAT_MAX;
    end else if (quot < 33'(SAT_MIN)) begin
      sat = SAT_MIN;
    end else begin
      sat = quot[15:0];
    end
  end

  // disallowed polarity is shut to zero after scaling
  // cut after scaling
  always_comb begin
    case (pol)
      POL_POS_ONLY: result = (sat < ZERO16) ? ZERO16 : sat;
      POL_NEG_ONLY: result = (sat > ZERO16) ? ZERO16 : sat;
      default: result = sat;
    endcase
  end
endmodule

// *** core/aux_analog_input_scaler.sv ***
// Purpose: three auxiliary input channels with gain, bias and polarity
// Assumes: samples arrive from converter logic on clk, one per cycle
// Notes: settings sit behind an AXI4-Lite slave; one shared datapath
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
module aux_analog_input_scaler
  import aux_scaler_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sample_valid,
  input wire logic [1:0] sample_channel,
  input wire logic signed [15:0] sample_data,
  output logic out_valid,
  output logic [1:0] out_channel,
  output logic signed [15:0] out_data,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  polarity_t pol_reg [NUM_CH];
  logic signed [15:0] offset_reg [NUM_CH];
  logic signed [15:0] scale_reg [NUM_CH];
  logic signed [15:0] result_reg [NUM_CH];
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic aw_full_reg;
  logic w_full_reg;
  logic aw_take, w_take, ar_take, commit;
  logic aw_full_next, w_full_next, rvalid_next;
  logic [1:0] wr_ch, wr_fld;
  logic [31:0] merged;
  polarity_t sel_pol;
  logic signed [15:0] sel_gain, sel_bias, math_result;
  logic ch_ok;

  // register space is the low 48 bytes; anything else answers SLVERR
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a[ADDR_W-1 -: 2] == ADDR_TOP_ZERO) &&
               (int'(a[CH_LSB +: 2]) < NUM_CH);
  endfunction

  function automatic logic [31:0] merge_word(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
    merge_word = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge_word[8*b +: 8] = data[8*b +: 8];
      end
    end
  endfunction

  // out of range gain and bias writes are pinned to the nearest limit
  function automatic logic signed [15:0] clamp16(
      input logic signed [15:0] v, input logic signed [15:0] lo,
      input logic signed [15:0] hi);
    if (v < lo) begin
      clamp16 = lo;
    end else if (v > hi) begin
      clamp16 = hi;
    end else begin
      clamp16 = v;
    end
  endfunction

  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a);
    logic [1:0] ch;
    logic [1:0] fld;
    ch = a[CH_LSB +: 2];
    fld = a[FLD_LSB +: 2];
    if (!addr_hit(a)) begin
      read_word = ZERO32;
    end else if (fld == FLD_POL) begin
      read_word = {30'h0000_0000, pol_reg[ch]};
    end else if (fld == FLD_OFFSET) begin
      read_word = {16'h0000, offset_reg[ch]};
    end else if (fld == FLD_SCALE) begin
      read_word = {16'h0000, scale_reg[ch]};
    end else begin
      read_word = {16'h0000, result_reg[ch]};
    end
  endfunction

  // handshake terms; address and data may arrive in either order
  always_comb begin
    aw_take = awvalid && awready;
    w_take = wvalid && wready;
    ar_take = arvalid && arready;
    commit = aw_full_reg && w_full_reg && !bvalid;
    aw_full_next = (aw_full_reg || aw_take) && !commit;
    w_full_next = (w_full_reg || w_take) && !commit;
    rvalid_next = (rvalid && !rready) || ar_take;
    wr_ch = aw_addr_reg[CH_LSB +: 2];
    wr_fld = aw_addr_reg[FLD_LSB +: 2];
    merged = merge_word(ZERO32, w_data_reg, w_strb_reg);
  end

  // write address and data holding, response after both
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_addr_reg <= '0;
      w_data_reg <= ZERO32;
      w_strb_reg <= 4'h0;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_addr_reg <= awaddr;
      end
      if (w_take) begin
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      awready <= !aw_full_next;
      wready <= !w_full_next;
      if (commit) begin
        bvalid <= 1'b1;
        bresp <= addr_hit(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // settings; lanes not strobed read as zero, so write whole halfwords
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        pol_reg[i] <= POL_BIPOLAR;
        offset_reg[i] <= BIAS_RST;
        scale_reg[i] <= GAIN_RST;
      end
    end else if (commit && addr_hit(aw_addr_reg)) begin
      if (wr_fld == FLD_POL) begin
        if (merged <= POL_CODE_MAX) begin
          pol_reg[wr_ch] <= polarity_t'(merged[1:0]);
        end
      end else if (wr_fld == FLD_OFFSET) begin
        offset_reg[wr_ch] <= clamp16(merged[15:0], BIAS_MIN, BIAS_MAX);
      end else if (wr_fld == FLD_SCALE) begin
        scale_reg[wr_ch] <= clamp16(merged[15:0], GAIN_MIN, GAIN_MAX);
      end
    end
  end

  // read channel; one outstanding read, data fixed while rvalid
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= ZERO32;
      rresp <= RESP_OKAY;
    end else begin
      arready <= !rvalid_next;
      rvalid <= rvalid_next;
      if (ar_take) begin
        rdata <= read_word(araddr);
        rresp <= addr_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_comb begin
    ch_ok = int'(sample_channel) < NUM_CH;
    sel_pol = ch_ok ? pol_reg[sample_channel] : POL_BIPOLAR;
    sel_gain = ch_ok ? scale_reg[sample_channel] : GAIN_RST;
    sel_bias = ch_ok ? offset_reg[sample_channel] : BIAS_RST;
  end

  aux_channel_math u_math (
    .sample(sample_data),
    .gain(sel_gain),
    .bias(sel_bias),
    .pol(sel_pol),
    .result(math_result)
  );

  // one cycle from sample to result; channel code 3 is dropped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_valid <= 1'b0;
      out_channel <= 2'h0;
      out_data <= ZERO16;
      for (int i = 0; i < NUM_CH; i++) begin
        result_reg[i] <= ZERO16;
      end
    end else begin
      out_valid <= sample_valid && ch_ok;
      if (sample_valid && ch_ok) begin
        out_channel <= sample_channel;
        out_data <= math_result;
        result_reg[sample_channel] <= math_result;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_out_follows;
    sample_valid && ch_ok |=>
      out_valid && out_channel == $past(sample_channel);
  endproperty
  a_out_follows: assert property (p_out_follows)
    else $error("result did not follow sample by one cycle");

  property p_pol_legal;
    pol_reg[0] <= POL_NEG_ONLY && pol_reg[1] <= POL_NEG_ONLY &&
      pol_reg[2] <= POL_NEG_ONLY;
  endproperty
  a_pol_legal: assert property (p_pol_legal)
    else $error("polarity code outside 0 to 2");

  property p_after_gain;
    out_valid && $past(sel_pol) == POL_POS_ONLY &&
      $past(sample_data) < ZERO16 && $past(sample_data) != SAT_MIN &&
      $past(sel_gain) == -GAIN_RST && $past(sel_bias) == ZERO16
      |-> out_data == -$past(sample_data);
  endproperty
  a_after_gain: assert property (p_after_gain)
    else $error("polarity applied before gain");

  property p_pos_only;
    out_valid && $past(sel_pol) == POL_POS_ONLY |-> out_data >= ZERO16;
  endproperty
  a_pos_only: assert property (p_pos_only)
    else $error("negative value passed in positive-only mode");

  property p_neg_only;
    out_valid && $past(sel_pol) == POL_NEG_ONLY |-> out_data <= ZERO16;
  endproperty
  a_neg_only: assert property (p_neg_only)
    else $error("positive value passed in negative-only mode");

  property p_bias_zero_in;
    sample_valid && ch_ok && sample_data == ZERO16 &&
      sel_pol == POL_BIPOLAR && sel_bias <= BIAS_LINEAR_MAX &&
      sel_bias >= -BIAS_LINEAR_MAX
      |=> out_data == 16'($past(sel_bias) * BIAS_STEP);
  endproperty
  a_bias_zero_in: assert property (p_bias_zero_in)
    else $error("zero input did not give bias level");

  property p_scale_range;
    scale_reg[0] >= GAIN_MIN && scale_reg[0] <= GAIN_MAX &&
      offset_reg[1] >= BIAS_MIN && offset_reg[1] <= BIAS_MAX;
  endproperty
  a_scale_range: assert property (p_scale_range)
    else $error("setting outside its range");

  property p_unity;
    sample_valid && ch_ok && sel_gain == GAIN_RST &&
      sel_bias == ZERO16 && sel_pol == POL_BIPOLAR
      |=> out_data == $past(sample_data);
  endproperty
  a_unity: assert property (p_unity)
    else $error("unity gain changed the sample");

  property p_no_wrap;
    out_valid && $past(sample_data) > ZERO16 &&
      $past(sel_gain) > ZERO16 && $past(sel_bias) >= ZERO16
      |-> out_data >= ZERO16;
  endproperty
  a_no_wrap: assert property (p_no_wrap)
    else $error("scaled result wrapped");
endmodule

// *** bench/adc_model.sv ***
// Purpose: converter model feeding samples to the scaler
// Assumes: one result per clock at most, channels rotate 0,1,2,3
// Notes: slot 3 carries no channel, so the scaler must drop it
`timescale 1ns/1ps
module adc_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic en,
  input wire logic slow,
  output logic sample_valid,
  output logic [1:0] sample_channel,
  output logic signed [15:0] sample_data
);
  logic [1:0] slot;
  // idle lines flip each cycle so stale data can never pass as a sample
  // three channels share the stream
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sample_valid <= 1'b0;
      sample_channel <= 2'h0;
      sample_data <= 16'sh0000;
      slot <= 2'h0;
    end else if (en && (!slow || $urandom_range(3) == 0)) begin
      sample_valid <= 1'b1;
      sample_channel <= slot;
      // zero samples now and then expose the bias-only level
      sample_data <= ($urandom_range(7) == 0) ? 16'sh0000 : 16'($urandom);
      slot <= slot + 2'h1;
    end else begin
      sample_valid <= 1'b0;
      sample_channel <= ~sample_channel;
      sample_data <= ~sample_data;
    end
  end
endmodule

// *** bench/aux_analog_input_scaler_tb.sv ***
// Purpose: self-checking bench for the auxiliary input scaler
// Assumes: the slave answers each bus request within 100 cycles
// Notes: a queue model predicts every stream result
`timescale 1ns/1ps
module aux_analog_input_scaler_tb;
  import aux_scaler_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, en = 1'b0, slow = 1'b0;
  logic sample_valid, out_valid, awready, wready, bvalid, arready, rvalid;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [1:0] sample_channel, out_channel, bresp, rresp;
  logic signed [15:0] sample_data, out_data;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0] wstrb = 4'hF;
  int n_mismatch = 0, total_checks = 0, k;
  int gain[3], bias[3], pol[3], last[3], q[$], qc[$];
  always #2.5 clk = ~clk;
  adc_model partner (.clk(clk), .arst_n(arst_n), .en(en), .slow(slow),
    .sample_valid(sample_valid), .sample_channel(sample_channel),
    .sample_data(sample_data));
  aux_analog_input_scaler uut (.clk(clk), .arst_n(arst_n),
    .sample_valid(sample_valid), .sample_channel(sample_channel),
    .sample_data(sample_data), .out_valid(out_valid),
    .out_channel(out_channel), .out_data(out_data), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task check_reg(string what, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task check_resp(string what, logic [1:0] e, logic [1:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task check_out(int ec, int ed);
    total_checks++;
    if (out_channel !== 2'(ec) || out_data !== 16'(ed)) begin
      n_mismatch++;
      $display("Error out expected %0d %0d seen %0d %0d", ec, ed,
        out_channel, out_data);
    end
  endtask
  task timed_out;
    n_mismatch++;
    $display("Error handshake expected answer seen none");
    summarize();
  endtask
  // write address and data offered together, bready held from the start
  task wr(logic [7:0] a, logic [31:0] v, logic [1:0] er);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 100) timed_out();
    bready <= 1'b0;
    check_resp("bresp", er, bresp);
  endtask
  task rd(logic [7:0] a, logic [31:0] e, logic [1:0] er);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 100) timed_out();
    rready <= 1'b0;
    check_resp("rresp", er, rresp);
    check_reg("rdata", e, rdata);
  endtask
  function automatic logic [7:0] ad(int c, int f);
    return 8'(c * 16 + f * 4);
  endfunction
  function automatic logic [31:0] w16(int v);
    return {16'h0000, 16'(v)};
  endfunction
  // gain first, then bias, saturate, then the polarity cut
  function automatic int model(int s, int c);
    int v;
    v = (s * gain[c] + bias[c] * 10000) / 1000;
    if (v > 32767) v = 32767;
    if (v < -32768) v = -32768;
    if (pol[c] == 1 && v < 0) v = 0;
    if (pol[c] == 2 && v > 0) v = 0;
    return v;
  endfunction
  // each result must come exactly one edge after its sample
  always @(posedge clk) begin
    if (arst_n && out_valid === 1'b1) begin
      if (q.size() != 1) check_reg("latency", 1, q.size());
      else check_out(qc.pop_front(), q.pop_front());
      q.delete();
      qc.delete();
    end
    if (arst_n && sample_valid && sample_channel < 2'h3) begin
      qc.push_back(sample_channel);
      q.push_back(model($signed(sample_data), sample_channel));
      last[sample_channel] = q[$];
    end
  end
  task do_reset;
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    for (int c = 0; c < 3; c++) begin
      gain[c] = 1000;
      bias[c] = 0;
      pol[c] = 0;
      last[c] = 0;
    end
  endtask
  task readback;
    for (int c = 0; c < 3; c++) begin
      rd(ad(c, 0), pol[c], RESP_OKAY);
      rd(ad(c, 1), w16(bias[c]), RESP_OKAY);
      rd(ad(c, 2), w16(gain[c]), RESP_OKAY);
      rd(ad(c, 3), w16(last[c]), RESP_OKAY);
    end
  endtask
  // random settings; illegal code and result writes must not stick
  task setup(int p);
    for (int c = 0; c < 3; c++) begin
      gain[c] = int'($urandom_range(16000)) - 8000;
      bias[c] = int'($urandom_range(8000)) - 4000;
      pol[c] = (c + p) % 3;
      wr(ad(c, 0), pol[c], RESP_OKAY);
      wr(ad(c, 0), 32'h0000_0003, RESP_OKAY);
      wr(ad(c, 1), w16(bias[c]), RESP_OKAY);
      wr(ad(c, 2), w16(gain[c]), RESP_OKAY);
      wr(ad(c, 3), 32'h0000_0055, RESP_OKAY);
    end
  endtask
  task stream(logic s);
    slow <= s;
    en <= 1'b1;
    repeat (80) @(posedge clk);
    en <= 1'b0;
    repeat (3) @(posedge clk);
    check_reg("pending", 0, q.size());
  endtask
  initial begin
    void'($urandom(84));
    do_reset();
    readback();
    rd(8'h30, ZERO32, RESP_SLVERR);
    wr(8'h40, 32'h0000_0002, RESP_SLVERR);
    // default settings must pass samples straight through
    stream(1'b0);
    readback();
    $display("test defaults done");
    for (k = 0; k < 3; k++) begin
      setup(k);
      stream(k[0]);
      readback();
      $display("test polarity set %0d done", k);
    end
    // out of range settings clamp to the limits, then saturate hard
    wr(ad(1, 2), 32'h0000_2328, RESP_OKAY);
    wr(ad(1, 1), 32'h0000_EC78, RESP_OKAY);
    gain[1] = 8000;
    bias[1] = -4000;
    // negated unity gain with positive-only cut: sign set after gain
    wr(ad(0, 2), w16(-1000), RESP_OKAY);
    wr(ad(0, 1), w16(0), RESP_OKAY);
    wr(ad(0, 0), 32'h0000_0001, RESP_OKAY);
    gain[0] = -1000;
    bias[0] = 0;
    pol[0] = 1;
    stream(1'b0);
    readback();
    $display("test clamp done");
    do_reset();
    readback();
    $display("test second reset done");
    summarize();
  end
endmodule
